// file: gcdf_pkg.sv
// Package with register map, field layout and constants of the GPU clock divider block
package gcdf_pkg;
   localparam int GCDF_ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] GCDF_OFF_DIV_ONE = 8'h00;
   localparam logic [7:0] GCDF_OFF_DIV_TWO = 8'h04;
   localparam logic [7:0] GCDF_OFF_BUS_DIV = 8'h08;
   localparam logic [7:0] GCDF_OFF_FORCE_STATE = 8'h0C;
   localparam logic [7:0] GCDF_OFF_FORCE_SET = 8'h10;
   localparam logic [7:0] GCDF_OFF_FORCE_CLR = 8'h14;
   localparam logic [7:0] GCDF_OFF_SOURCE_CTRL = 8'h18;
   // Field positions
   localparam int GCDF_CORE_REQ_LSB = 0;
   localparam int GCDF_CORE_ACT_LSB = 16;
   localparam int GCDF_CORE_DIV_W = 5;
   localparam int GCDF_BUS_REQ_LSB = 4;
   localparam int GCDF_BUS_ACT_LSB = 12;
   localparam int GCDF_BUS_DIV_W = 4;
   localparam int GCDF_FORCE_CORE_BIT = 1;
   localparam int GCDF_FORCE_BUS_BIT = 2;
   localparam int GCDF_FORCE_TRACE_BIT = 3;
   localparam int GCDF_SEL_W = 8;
   // Source select encodings
   localparam logic [7:0] GCDF_SEL_GATED = 8'h00;
   localparam logic [7:0] GCDF_SEL_REF = 8'h01;
   localparam logic [7:0] GCDF_SEL_SYSPLL = 8'h02;
   localparam logic [7:0] GCDF_SEL_GFXPLL = 8'h04;
   // Reset values and response codes
   localparam logic [4:0] GCDF_CORE_DIV_RST = 5'h00;
   localparam logic [3:0] GCDF_BUS_DIV_RST = 4'h0;
   localparam logic [2:0] GCDF_FORCE_RST = 3'h0;
   localparam logic [1:0] GCDF_RESP_OKAY = 2'h0;
   localparam logic [1:0] GCDF_RESP_SLVERR = 2'h2;
endpackage

// file: gcdf_divider.sv
// Glitch free integer clock enable divider with active ratio readback
`timescale 1ns/1ns
module gcdf_divider
   import gcdf_pkg::*;
#(
   parameter int W = 5
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic count_en,
   input wire logic [W-1:0] divider_request,
   output logic [W-1:0] divider_active,
   output logic tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] act;
   } gcdf_div_s;
   gcdf_div_s cur;
   gcdf_div_s next_cur;

   // Count enables from zero up to the active ratio; new ratio taken only at a period boundary
   always_comb
   begin
      next_cur = cur;
      if (count_en)
      begin
         if (cur.cnt >= cur.act)
         begin
            next_cur.cnt = '0;
            next_cur.act = divider_request;
         end
         else
         begin
            next_cur.cnt = cur.cnt + 1'b1;
         end
      end
   end

   // State register, cleared to divide by one
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         cur <= '0;
      else
         cur <= next_cur;
   end

   // Active ratio readback and period end pulse
   assign divider_active = cur.act;
   assign tick = count_en && (cur.cnt >= cur.act);

   property p_ratio;
      @(posedge sys_clk) disable iff (!arst_n)
      count_en && !tick |=> cur.cnt == $past(cur.cnt) + 1'b1;
   endproperty
   a_ratio: assert property (p_ratio) else $error("divider count skipped a step");

   property p_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      !tick |=> $stable(cur.act);
   endproperty
   a_hold: assert property (p_hold) else $error("active ratio changed mid period");
endmodule

// file: gcdf_top.sv
// GPU core and bus clock dividers with clock force state behind AXI4-Lite
`timescale 1ns/1ns
module gcdf_top
   import gcdf_pkg::*;
#(
   parameter bit HAS_CORE_GATING = 1'b1,
   parameter bit HAS_TRACE = 1'b1
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic gpu_core_clock_en,
   output logic gpu_bus_clock_en,
   output logic [7:0] source_select,
   output logic core_clock_force,
   output logic bus_clock_force,
   output logic trace_clock_force
);
   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [4:0] req_one;
      logic [4:0] req_two;
      logic [3:0] req_bus;
      logic [7:0] sel;
      logic [2:0] force_bits; // trace, bus, core
   } gcdf_top_s;
   gcdf_top_s cur;
   gcdf_top_s next_cur;

   logic [4:0] act_one;
   logic [4:0] act_two;
   logic [3:0] act_bus;
   logic tick_one;
   logic tick_two;
   logic tick_bus;
   logic [2:0] force_mask;
   logic core_tick;

   // Core dividers; each belongs to one source
   gcdf_divider #(.W(GCDF_CORE_DIV_W)) u_div_one (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .count_en(1'b1),
      .divider_request(cur.req_one),
      .divider_active(act_one),
      .tick(tick_one)
   );
   gcdf_divider #(.W(GCDF_CORE_DIV_W)) u_div_two (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .count_en(1'b1),
      .divider_request(cur.req_two),
      .divider_active(act_two),
      .tick(tick_two)
   );

   // Selected core clock enable per source select code
   always_comb
   begin
      core_tick = 1'b0;
      case (cur.sel)
         GCDF_SEL_GATED: core_tick = 1'b0;
         GCDF_SEL_REF: core_tick = 1'b1;
         GCDF_SEL_SYSPLL: core_tick = tick_one;
         GCDF_SEL_GFXPLL: core_tick = tick_two;
         default: core_tick = 1'b0;
      endcase
   end

   // Bus divider counts only on core clock enables
   gcdf_divider #(.W(GCDF_BUS_DIV_W)) u_bus (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .count_en(core_tick),
      .divider_request(cur.req_bus),
      .divider_active(act_bus),
      .tick(tick_bus)
   );

   assign force_mask = {HAS_TRACE, 1'b1, HAS_CORE_GATING};

   // Bus slave and register state
   always_comb
   begin
      logic wr_go;
      logic [31:0] wv;
      wr_go = 1'b0;
      wv = '0;
      next_cur = cur;
      if (s_axi_awvalid && !cur.aw_got)
      begin
         next_cur.aw_got = 1'b1;
         next_cur.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !cur.w_got)
      begin
         next_cur.w_got = 1'b1;
         next_cur.w_data = s_axi_wdata;
         next_cur.w_strb = s_axi_wstrb;
      end
      if (cur.bvalid && s_axi_bready)
         next_cur.bvalid = 1'b0;
      if (cur.aw_got && cur.w_got && !cur.bvalid)
      begin
         wr_go = 1'b1;
         next_cur.aw_got = 1'b0;
         next_cur.w_got = 1'b0;
         next_cur.bvalid = 1'b1;
         next_cur.bresp = GCDF_RESP_OKAY;
         wv = cur.w_data;
      end
      if (wr_go)
      begin
         case ({cur.aw_addr[7:2], 2'b00})
            GCDF_OFF_DIV_ONE:
               if (cur.w_strb[0])
                  next_cur.req_one = wv[GCDF_CORE_REQ_LSB +: GCDF_CORE_DIV_W];
            GCDF_OFF_DIV_TWO:
               if (cur.w_strb[0])
                  next_cur.req_two = wv[GCDF_CORE_REQ_LSB +: GCDF_CORE_DIV_W];
            GCDF_OFF_BUS_DIV:
               if (cur.w_strb[0])
                  next_cur.req_bus = wv[GCDF_BUS_REQ_LSB +: GCDF_BUS_DIV_W];
            GCDF_OFF_FORCE_SET:
               if (cur.w_strb[0])
                  next_cur.force_bits = cur.force_bits
                     | (wv[GCDF_FORCE_TRACE_BIT:GCDF_FORCE_CORE_BIT] & force_mask);
            GCDF_OFF_FORCE_CLR:
               if (cur.w_strb[0])
                  next_cur.force_bits = cur.force_bits
                     & ~(wv[GCDF_FORCE_TRACE_BIT:GCDF_FORCE_CORE_BIT] & force_mask);
            GCDF_OFF_SOURCE_CTRL:
               if (cur.w_strb[0])
                  next_cur.sel = wv[GCDF_SEL_W-1:0];
            GCDF_OFF_FORCE_STATE: next_cur.bresp = GCDF_RESP_OKAY; // Read only, write ignored
            default: next_cur.bresp = GCDF_RESP_SLVERR;
         endcase
      end
      if (cur.rvalid && s_axi_rready)
         next_cur.rvalid = 1'b0;
      if (s_axi_arvalid && !cur.rvalid)
      begin
         next_cur.rvalid = 1'b1;
         next_cur.rresp = GCDF_RESP_OKAY;
         next_cur.rdata = '0;
         case ({s_axi_araddr[7:2], 2'b00})
            GCDF_OFF_DIV_ONE:
            begin
               next_cur.rdata[GCDF_CORE_REQ_LSB +: GCDF_CORE_DIV_W] = cur.req_one;
               next_cur.rdata[GCDF_CORE_ACT_LSB +: GCDF_CORE_DIV_W] = act_one;
            end
            GCDF_OFF_DIV_TWO:
            begin
               next_cur.rdata[GCDF_CORE_REQ_LSB +: GCDF_CORE_DIV_W] = cur.req_two;
               next_cur.rdata[GCDF_CORE_ACT_LSB +: GCDF_CORE_DIV_W] = act_two;
            end
            GCDF_OFF_BUS_DIV:
            begin
               next_cur.rdata[GCDF_BUS_REQ_LSB +: GCDF_BUS_DIV_W] = cur.req_bus;
               next_cur.rdata[GCDF_BUS_ACT_LSB +: GCDF_BUS_DIV_W] = act_bus;
            end
            GCDF_OFF_FORCE_STATE:
               next_cur.rdata[GCDF_FORCE_TRACE_BIT:GCDF_FORCE_CORE_BIT] =
                  cur.force_bits & force_mask;
            GCDF_OFF_SOURCE_CTRL: next_cur.rdata[GCDF_SEL_W-1:0] = cur.sel;
            GCDF_OFF_FORCE_SET: next_cur.rdata = '0; // Write only
            GCDF_OFF_FORCE_CLR: next_cur.rdata = '0;
            default: next_cur.rresp = GCDF_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cur <= '0;
         cur.req_one <= GCDF_CORE_DIV_RST;
         cur.req_two <= GCDF_CORE_DIV_RST;
         cur.req_bus <= GCDF_BUS_DIV_RST;
         cur.sel <= GCDF_SEL_GATED;
         cur.force_bits <= GCDF_FORCE_RST;
      end
      else
         cur <= next_cur;
   end

   // Handshake and output drive
   assign s_axi_awready = !cur.aw_got;
   assign s_axi_wready = !cur.w_got;
   assign s_axi_bvalid = cur.bvalid;
   assign s_axi_bresp = cur.bresp;
   assign s_axi_arready = !cur.rvalid;
   assign s_axi_rvalid = cur.rvalid;
   assign s_axi_rresp = cur.rresp;
   assign s_axi_rdata = cur.rdata;
   assign gpu_core_clock_en = core_tick;
   assign gpu_bus_clock_en = tick_bus;
   assign source_select = cur.sel;
   assign core_clock_force = cur.force_bits[0];
   assign bus_clock_force = cur.force_bits[1];
   assign trace_clock_force = cur.force_bits[2];

   sequence s_wr_to(logic [7:0] off);
      cur.aw_got && cur.w_got && !cur.bvalid && {cur.aw_addr[7:2], 2'b00} == off
         && cur.w_strb[0];
   endsequence

   property p_set;
      @(posedge sys_clk) disable iff (!arst_n)
      s_wr_to(GCDF_OFF_FORCE_SET) |=> (cur.force_bits & $past(cur.force_bits))
         == $past(cur.force_bits);
   endproperty
   a_set: assert property (p_set) else $error("set write cleared a force bit");

   property p_set_one;
      @(posedge sys_clk) disable iff (!arst_n)
      s_wr_to(GCDF_OFF_FORCE_SET) ##0 cur.w_data[GCDF_FORCE_BUS_BIT] |=> bus_clock_force;
   endproperty
   a_set_one: assert property (p_set_one) else $error("bus force not set");

   property p_clr;
      @(posedge sys_clk) disable iff (!arst_n)
      s_wr_to(GCDF_OFF_FORCE_CLR) ##0 cur.w_data[GCDF_FORCE_BUS_BIT] |=> !bus_clock_force;
   endproperty
   a_clr: assert property (p_clr) else $error("bus force not cleared");

   property p_trace;
      @(posedge sys_clk) disable iff (!arst_n)
      !HAS_TRACE |-> !trace_clock_force;
   endproperty
   a_trace: assert property (p_trace) else $error("trace force without support");

   property p_core_cap;
      @(posedge sys_clk) disable iff (!arst_n)
      !HAS_CORE_GATING |-> !core_clock_force;
   endproperty
   a_core_cap: assert property (p_core_cap) else $error("core force without support");

   property p_req;
      @(posedge sys_clk) disable iff (!arst_n)
      s_wr_to(GCDF_OFF_DIV_ONE) |=>
         cur.req_one == $past(cur.w_data[GCDF_CORE_REQ_LSB +: GCDF_CORE_DIV_W]);
   endproperty
   a_req: assert property (p_req) else $error("divider one request not stored");

   property p_gated;
      @(posedge sys_clk) disable iff (!arst_n)
      cur.sel == GCDF_SEL_GATED |-> !gpu_core_clock_en && !gpu_bus_clock_en;
   endproperty
   a_gated: assert property (p_gated) else $error("gated source still ticking");

   property p_bus_sub;
      @(posedge sys_clk) disable iff (!arst_n)
      gpu_bus_clock_en |-> gpu_core_clock_en;
   endproperty
   a_bus_sub: assert property (p_bus_sub) else $error("bus tick outside core tick");
endmodule

// file: gcdf_top_bench.sv
// Self-checking bench of the GPU clock divider and clock force block
`timescale 1ns/1ns
`define check_eq(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module gcdf_top_bench
   import gcdf_pkg::*;
;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, sel, off;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rd_data, exp_v;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid, core_en, bus_en;
   logic core_frc, bus_frc, trace_frc;
   logic [2:0] frc_b;
   logic [31:0] rdata, rdata_b;
   int n_mismatch = 0, n_compared = 0, req[3], gap, force_m;
   // Device under test with both capabilities present
   gcdf_top i_gcdf_top (.sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .gpu_core_clock_en(core_en), .gpu_bus_clock_en(bus_en),
      .source_select(sel), .core_clock_force(core_frc), .bus_clock_force(bus_frc),
      .trace_clock_force(trace_frc));
   // Second device without core gating or trace support, same bus stimulus
   gcdf_top #(.HAS_CORE_GATING(1'b0), .HAS_TRACE(1'b0)) i_gcdf_top_bare (.sys_clk(sys_clk),
      .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata_b), .s_axi_rresp(),
      .s_axi_rvalid(), .s_axi_rready(rready), .gpu_core_clock_en(), .gpu_bus_clock_en(),
      .source_select(), .core_clock_force(frc_b[0]), .bus_clock_force(frc_b[1]),
      .trace_clock_force(frc_b[2]));
   // Clock generation
   always #5 sys_clk = ~sys_clk;
   // Verdict and end of run
   task test_done;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_mismatch);
         if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // AXI4-Lite write, address and data offered together
   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_done, w_done;
      begin
         aw_done = 0;
         w_done = 0;
         @(posedge sys_clk);
         awaddr <= a;
         awvalid <= 1'b1;
         wdata <= d;
         wstrb <= 4'hF;
         wvalid <= 1'b1;
         bready <= 1'b1;
         while (!(aw_done && w_done))
         begin
            @(posedge sys_clk);
            if (!aw_done && awready === 1'b1)
            begin
               aw_done = 1;
               awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
               w_done = 1;
               wvalid <= 1'b0;
            end
         end
         do
         begin
            @(posedge sys_clk);
         end while (bvalid !== 1'b1);
         r = bresp;
         bready <= 1'b0;
      end
   endtask
   // AXI4-Lite read
   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar_done;
      begin
         ar_done = 0;
         @(posedge sys_clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do
         begin
            @(posedge sys_clk);
            if (!ar_done && arready === 1'b1)
            begin
               ar_done = 1;
               arvalid <= 1'b0;
            end
         end while (!(ar_done && rvalid === 1'b1));
         d = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask
   // Write and compare the response code
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      begin
         axi_wr(a, d, resp);
         `check_eq(resp, er)
      end
   endtask
   // Read, optionally retrying until a divider change lands, then compare
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input int tries);
      begin
         for (int k = 0; k <= tries; k++)
         begin
            axi_rd(a, rd_data, resp);
            if (rd_data === e)
               break;
         end
         `check_eq(rd_data, e)
         `check_eq(resp, er)
      end
   endtask
   // Cycles between the second and third enable pulse
   task gap_of(input bit bus, output int g);
      begin
         for (int k = 0; k < 3; k++)
         begin
            g = 0;
            do
            begin
               @(negedge sys_clk);
               g++;
            end while ((bus ? bus_en : core_en) !== 1'b1);
         end
      end
   endtask
   // Watchdog
   initial
   begin
      #800000;
      n_mismatch++;
      test_done();
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'h60f0a05d));
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      // Reset values and write-only registers read zero
      for (int a = 0; a < 8'h1C; a += 4)
         rd(a[7:0], 32'h0, GCDF_RESP_OKAY, 0);
      rd(8'h1C, 32'h0, GCDF_RESP_SLVERR, 0);
      wr(8'h1C, 32'hFF, GCDF_RESP_SLVERR);
      // Divider requests with random reserved bits, active follows request
      for (int k = 0; k < 3; k++)
      begin
         wr(GCDF_OFF_SOURCE_CTRL, (k == 1) ? 32'h4 : 32'h2, GCDF_RESP_OKAY);
         wdata <= $urandom;
         @(posedge sys_clk);
         off = GCDF_OFF_DIV_ONE + 8'(4 * k);
         req[k] = (k == 2) ? int'(wdata[7:4]) : int'(wdata[4:0]);
         exp_v = (k == 2) ? ((32'(req[k]) << 4) | (32'(req[k]) << 12))
            : (32'(req[k]) | (32'(req[k]) << 16));
         wr(off, wdata, GCDF_RESP_OKAY);
         rd(off, exp_v, GCDF_RESP_OKAY, 300);
      end
      // Core and bus enable spacing per source
      wr(GCDF_OFF_SOURCE_CTRL, 32'h302, GCDF_RESP_OKAY);
      `check_eq(sel, GCDF_SEL_SYSPLL)
      gap_of(0, gap);
      `check_eq(gap, req[0] + 1)
      gap_of(1, gap);
      `check_eq(gap, (req[0] + 1) * (req[2] + 1))
      wr(GCDF_OFF_SOURCE_CTRL, 32'h4, GCDF_RESP_OKAY);
      gap_of(0, gap);
      `check_eq(gap, req[1] + 1)
      wr(GCDF_OFF_SOURCE_CTRL, 32'h1, GCDF_RESP_OKAY);
      gap_of(1, gap);
      `check_eq(gap, req[2] + 1)
      wr(GCDF_OFF_SOURCE_CTRL, 32'h0, GCDF_RESP_OKAY);
      gap = 0;
      repeat (3) @(negedge sys_clk);
      repeat (60)
      begin
         @(negedge sys_clk);
         gap += int'(core_en === 1'b1 || bus_en === 1'b1);
      end
      `check_eq(gap, 0)
      // Force set, zero write, clear and reserved bits; bare device masks core and trace
      force_m = 32'hE;
      wr(GCDF_OFF_FORCE_SET, 32'hE, GCDF_RESP_OKAY);
      rd(GCDF_OFF_FORCE_STATE, force_m, GCDF_RESP_OKAY, 0);
      `check_eq({trace_frc, bus_frc, core_frc}, 3'h7)
      `check_eq(rdata_b, force_m & 32'h4)
      `check_eq(frc_b, 3'h2)
      wr(GCDF_OFF_FORCE_SET, 32'h0, GCDF_RESP_OKAY);
      rd(GCDF_OFF_FORCE_STATE, force_m, GCDF_RESP_OKAY, 0);
      force_m = force_m & ~32'h4;
      wr(GCDF_OFF_FORCE_CLR, 32'h4, GCDF_RESP_OKAY);
      rd(GCDF_OFF_FORCE_STATE, force_m, GCDF_RESP_OKAY, 0);
      `check_eq({trace_frc, bus_frc, core_frc}, 3'h5)
      `check_eq(frc_b, 3'h0)
      wr(GCDF_OFF_FORCE_CLR, 32'hA, GCDF_RESP_OKAY);
      wr(GCDF_OFF_FORCE_SET, 32'hFFFFFFF1, GCDF_RESP_OKAY);
      rd(GCDF_OFF_FORCE_STATE, 32'h0, GCDF_RESP_OKAY, 0);
      rd(GCDF_OFF_FORCE_SET, 32'h0, GCDF_RESP_OKAY, 0);
      test_done();
   end
endmodule
